//--- rtl/dsa_pkg.sv
/*
  Shared constants and types for the slice arithmetic stage: widths,
  stage selects, rounding modes, flag bundle and the random source seed.
  Assumes every file that needs them imports the whole package.
*/
package dsa_pkg;

  // ****************************************************
  // Widths and counts
  // ****************************************************
  localparam int DSA_W = 54;
  localparam int DSA_MUL_A_W = 18;
  localparam int DSA_MUL_B_W = 36;
  localparam int DSA_SEL_W = 2;
  localparam int DSA_NSRC = 4;
  localparam int DSA_RND_W = 6;
  localparam int DSA_EXT_W = 56;
  localparam logic [5:0] DSA_MAX_RND = 6'h35;
  localparam int DSA_LFSR_W = 16;

  // ****************************************************
  // Reset values and constants
  // ****************************************************
  localparam logic [15:0] DSA_LFSR_SEED = 16'hace1;
  localparam logic [15:0] DSA_LFSR_TAPS = 16'hb400;
  localparam logic [53:0] DSA_ONE = 54'h1;
  localparam logic [53:0] DSA_ZERO = 54'h0;
  localparam logic [53:0] DSA_ALL_ONES = 54'h3fffffffffffff;

  // ****************************************************
  // Enumerations
  // ****************************************************
  typedef enum logic [2:0]
  {
    RND_NONE,
    RND_TOWARD_ZERO,
    RND_TOWARD_INFINITY,
    RND_DYNAMIC,
    RND_RANDOM,
    RND_CONVERGENT
  } dsa_round_type;

  typedef enum logic [1:0]
  {
    THIRD_C,
    THIRD_CASCADE,
    THIRD_ZERO
  } dsa_third_type;

  // ****************************************************
  // Bundles
  // ****************************************************
  typedef struct packed
  {
    logic [1:0] clk_sel;
    logic [1:0] ce_sel;
    logic [1:0] rst_sel;
  } dsa_stage_cfg_type;

  typedef struct packed
  {
    logic zero_match_flag;
    logic masked_zero_match_flag;
    logic masked_ones_match_flag;
    logic pattern_match_flag;
    logic inverse_pattern_match_flag;
    logic over_flag;
    logic under_flag;
    logic either_wrap_flag;
  } dsa_flags_type;

  typedef struct packed
  {
    logic [17:0] mul_a;
    logic [35:0] mul_b;
    logic [53:0] addend;
    logic [53:0] c_val;
  } dsa_in_type;

  typedef struct packed
  {
    logic [53:0] x_val;
    logic [53:0] c_val;
  } dsa_pipe_type;

  typedef struct packed
  {
    logic [53:0] result;
    dsa_flags_type flags;
  } dsa_out_type;

endpackage

//--- rtl/dsa_stage_reg.sv
/*
  One register stage of the slice with its own choice of clock source,
  clock enable and reset among four global candidates of each kind.
  Assumes the clock sources are one-cycle ticks synchronous to clk.
*/
`timescale 1ns/1ps
module dsa_stage_reg
  import dsa_pkg::*;
#(
  parameter int W = 8
)
(
  input wire logic clk, // System clock
  input wire logic rst_b, // Async reset, active low
  input wire logic [3:0] clk_src, // Global clock source ticks
  input wire logic [3:0] ce_src, // Global clock enables
  input wire logic [3:0] rst_src, // Global sync resets
  input wire dsa_stage_cfg_type cfg, // This stage's selections
  input wire logic [W-1:0] d, // Data in
  output logic [W-1:0] q // Registered data out
);

  // ****************************************************
  // Stage update
  // ****************************************************
  logic [W-1:0] next_q;
  logic tick;
  logic en;
  logic clr;

  assign tick = clk_src[cfg.clk_sel];
  assign en = ce_src[cfg.ce_sel];
  assign clr = rst_src[cfg.rst_sel];

  // Reset acts only on the stage's own tick, like a sync reset
  always_comb
  begin
    next_q = q;
    if (tick && clr)
      next_q = '0;
    else if (tick && en)
      next_q = d;
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      q <= '0;
    else
      q <= next_q;
  end

endmodule

//--- rtl/dsa_alu.sv
/*
  Arithmetic stage of a multiply-accumulate slice: input, pipeline and
  output stages, ternary adder with cascade, rounding and flags.
  Assumes operands and controls come from logic on the same clock.
*/
// Contract
// - Pass sums by cascade out, take cascade in, third operand multiplexed.
// - Multiplier can be bypassed; adder is 54 bits wide.
// - Round by adding a constant, then truncate.
// - Offer toward zero, toward infinity, dynamic, random, convergent.
// - Unmasked zero flag; masked zero, ones, pattern, inverse pattern.
// - Separate overflow and underflow flags plus their combined flag.
// - Each register stage picks its clock from four sources.
// - Each stage picks its own clock enable and reset.
// - Accumulator overflow is registered; accumulator loads dynamically.
// - Add or subtract choice may change every cycle, honoured at once.
`timescale 1ns/1ps
module dsa_alu
  import dsa_pkg::*;
(
  input wire logic clk, // System clock, 10 MHz
  input wire logic rst_b, // Async reset, active low
  input wire logic clock_source_a, // Global clock source tick 0
  input wire logic clock_source_b, // Global clock source tick 1
  input wire logic clock_source_c, // Global clock source tick 2
  input wire logic clock_source_d, // Global clock source tick 3
  input wire logic [3:0] ce_src, // Global clock enables
  input wire logic [3:0] rst_src, // Global sync resets
  input wire dsa_stage_cfg_type in_cfg, // Input stage selects
  input wire dsa_stage_cfg_type pipe_cfg, // Pipeline stage selects
  input wire dsa_stage_cfg_type out_cfg, // Output stage selects
  input wire logic [17:0] mul_a, // Multiplier operand A
  input wire logic [35:0] mul_b, // Multiplier operand B
  input wire logic [53:0] addend, // Operand used when bypassing
  input wire logic [53:0] c_in, // Third operand from fabric
  input wire logic [53:0] cascade_in, // Partial sum from prior slice
  input wire logic bypass_mult, // 1: adder only, skip product
  input wire dsa_third_type third_sel, // Third operand choice
  input wire logic acc_en, // 1: feed back accumulator
  input wire logic acc_load, // 1: initialise accumulator from C
  input wire logic add_sub, // 1: subtract, 0: add
  input wire dsa_round_type round_mode, // Rounding method
  input wire logic [5:0] round_bits, // Low bits dropped by rounding
  input wire logic round_dyn_up, // Dynamic rounding: halves go up
  input wire logic [53:0] mask, // Flag mask, 1 ignores bit
  input wire logic [53:0] pattern, // Pattern for match flags
  output logic [53:0] result, // Registered result
  output logic [53:0] cascade_out, // Registered sum to next slice
  output dsa_flags_type flags // Registered flags
);

  // ****************************************************
  // Stage registers
  // ****************************************************
  logic [3:0] clk_src;
  dsa_in_type in_d;
  dsa_in_type in_q;
  dsa_pipe_type pipe_d;
  dsa_pipe_type pipe_q;
  dsa_out_type out_d;
  dsa_out_type out_q;

  // four global clock ticks shared by stages
  assign clk_src = {clock_source_d, clock_source_c,
                    clock_source_b, clock_source_a};

  // Operands are captured in one shot
  assign in_d.mul_a = mul_a;
  assign in_d.mul_b = mul_b;
  assign in_d.addend = addend;
  assign in_d.c_val = c_in;

  dsa_stage_reg #(.W($bits(dsa_in_type))) u_in_stage
  (
    .clk(clk),
    .rst_b(rst_b),
    .clk_src(clk_src),
    .ce_src(ce_src),
    .rst_src(rst_src),
    .cfg(in_cfg),
    .d(in_d),
    .q(in_q)
  );

  // multiplier bypass for a plain adder
  always_comb
  begin
    pipe_d.c_val = in_q.c_val;
    if (bypass_mult)
      pipe_d.x_val = in_q.addend;
    else
      pipe_d.x_val = $signed(in_q.mul_a) * $signed(in_q.mul_b);
  end

  dsa_stage_reg #(.W($bits(dsa_pipe_type))) u_pipe_stage
  (
    .clk(clk),
    .rst_b(rst_b),
    .clk_src(clk_src),
    .ce_src(ce_src),
    .rst_src(rst_src),
    .cfg(pipe_cfg),
    .d(pipe_d),
    .q(pipe_q)
  );

  // ****************************************************
  // Random rounding source
  // ****************************************************
  logic [15:0] lfsr;
  logic [15:0] next_lfsr;
  logic [53:0] rand_bits;

  // Free-running so random rounding never repeats a stuck value
  always_comb
  begin
    next_lfsr = lfsr >> 1;
    if (lfsr[0])
      next_lfsr = (lfsr >> 1) ^ DSA_LFSR_TAPS;
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      lfsr <= DSA_LFSR_SEED;
    else
      lfsr <= next_lfsr;
  end

  assign rand_bits = {lfsr[5:0], lfsr, lfsr, lfsr};

  // ****************************************************
  // Ternary adder
  // ****************************************************
  logic [53:0] w_val;
  logic [53:0] z_val;
  logic [55:0] x_ext;
  logic [55:0] sum_ext;
  logic [53:0] sum;
  logic over;
  logic under;

  always_comb
  begin
    w_val = DSA_ZERO;
    if (acc_load)
      w_val = pipe_q.c_val;
    else if (acc_en)
      w_val = out_q.result;
  end

  always_comb
  begin
    case (third_sel)
      THIRD_C: z_val = pipe_q.c_val;
      THIRD_CASCADE: z_val = cascade_in;
      THIRD_ZERO: z_val = DSA_ZERO;
      default: z_val = DSA_ZERO;
    endcase
  end

  // add or subtract taken live this cycle
  always_comb
  begin
    x_ext = {{2{pipe_q.x_val[53]}}, pipe_q.x_val};
    if (add_sub)
      x_ext = ~x_ext + 56'h1;
    sum_ext = {{2{w_val[53]}}, w_val} + {{2{z_val[53]}}, z_val} + x_ext;
  end

  assign sum = sum_ext[53:0];
  // signed range checks on the full sum
  assign over = !sum_ext[55] && (sum_ext[54:53] != 2'b00);
  assign under = sum_ext[55] && (sum_ext[54:53] != 2'b11);

  // ****************************************************
  // Rounding
  // ****************************************************
  logic [5:0] k;
  logic [53:0] half;
  logic [53:0] low_mask;
  logic [53:0] rconst;
  logic [53:0] rounded;
  logic [53:0] trunc;

  // Clamp so the kept-bit index stays inside the word
  assign k = (round_bits > DSA_MAX_RND) ? DSA_MAX_RND : round_bits;
  assign half = (k == 6'h0) ? DSA_ZERO : (DSA_ONE << (k - 6'h1));
  assign low_mask = (DSA_ONE << k) - DSA_ONE;

  // pick the rounding constant by method
  always_comb
  begin
    rconst = DSA_ZERO;
    if (k != 6'h0)
    begin
      case (round_mode)
        RND_TOWARD_ZERO: rconst = sum[53] ? half : half - DSA_ONE;
        RND_TOWARD_INFINITY: rconst = sum[53] ? half - DSA_ONE : half;
        RND_DYNAMIC: rconst = round_dyn_up ? half : half - DSA_ONE;
        RND_RANDOM: rconst = rand_bits & low_mask;
        // ties go to the even neighbour
        RND_CONVERGENT: rconst = half - DSA_ONE + {53'h0, sum[k]};
        default: rconst = DSA_ZERO;
      endcase
    end
  end

  // add constant, then clear dropped bits
  // Rounding that crosses the top bit wraps; no saturation here
  always_comb
  begin
    rounded = sum + rconst;
    trunc = rounded;
    if (round_mode != RND_NONE)
      trunc = rounded & ~low_mask;
  end

  // ****************************************************
  // Flags
  // ****************************************************
  // zero, masked zero, ones, pattern, inverse
  always_comb
  begin
    out_d.result = trunc;
    out_d.flags.zero_match_flag = (trunc == DSA_ZERO);
    out_d.flags.masked_zero_match_flag = ((trunc & ~mask) == DSA_ZERO);
    out_d.flags.masked_ones_match_flag = ((trunc | mask) == DSA_ALL_ONES);
    out_d.flags.pattern_match_flag =
      (((trunc ^ pattern) & ~mask) == DSA_ZERO);
    out_d.flags.inverse_pattern_match_flag =
      (((trunc ^ ~pattern) & ~mask) == DSA_ZERO);
    out_d.flags.over_flag = over;
    out_d.flags.under_flag = under;
    out_d.flags.either_wrap_flag = over || under;
  end

  // result and wrap flags registered together
  dsa_stage_reg #(.W($bits(dsa_out_type))) u_out_stage
  (
    .clk(clk),
    .rst_b(rst_b),
    .clk_src(clk_src),
    .ce_src(ce_src),
    .rst_src(rst_src),
    .cfg(out_cfg),
    .d(out_d),
    .q(out_q)
  );

  // ****************************************************
  // Outputs
  // ****************************************************
  // registered sum feeds the next slice
  assign cascade_out = out_q.result;
  assign result = out_q.result;
  assign flags = out_q.flags;

endmodule

//--- verif/dsa_alu_assertions.sv
/*
  Checker on the slice ports: cascade copy, flags and stage selects.
  Assumes it is bound into every dsa_alu of the run.
*/
`timescale 1ns/1ps
module dsa_alu_chk
  import dsa_pkg::*;
(
  input wire logic clk, // clock
  input wire logic rst_b, // reset
  input wire logic clock_source_a, // tick 0
  input wire logic clock_source_b, // tick 1
  input wire logic clock_source_c, // tick 2
  input wire logic clock_source_d, // tick 3
  input wire logic [3:0] ce_src, // enables
  input wire logic [3:0] rst_src, // sync resets
  input wire dsa_stage_cfg_type out_cfg, // output selects
  input wire logic [53:0] mask, // flag mask
  input wire logic [53:0] pattern, // flag pattern
  input wire logic [53:0] result, // result
  input wire logic [53:0] cascade_out, // cascade copy
  input wire dsa_flags_type flags // flags
);
  logic [3:0] tick;
  logic take;
  logic clr;
  // Output stage moves only on its own tick, with enable or reset
  assign tick = {clock_source_d, clock_source_c, clock_source_b,
    clock_source_a};
  assign take = tick[out_cfg.clk_sel] & ce_src[out_cfg.ce_sel];
  assign clr = tick[out_cfg.clk_sel] & rst_src[out_cfg.rst_sel];
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  // A stage clear zeroes flags too, so it is kept out of flag checks
  sequence fresh;
    $changed(result) && !$past(clr);
  endsequence
  a_cascade_copy:
    assert property (cascade_out == result) else $error("cascade copy");
  a_zero_flag:
    assert property (fresh |-> flags.zero_match_flag == (result == 0))
    else $error("zero flag");
  a_masked_zero:
    assert property (fresh |-> flags.masked_zero_match_flag ==
      ((result & ~$past(mask)) == 0)) else $error("masked zero");
  a_masked_ones:
    assert property (fresh |-> flags.masked_ones_match_flag ==
      ((result | $past(mask)) == DSA_ALL_ONES)) else $error("ones");
  a_pattern_flag:
    assert property (fresh |-> flags.pattern_match_flag ==
      (((result ^ $past(pattern)) & ~$past(mask)) == 0))
    else $error("pattern flag");
  a_either_flag:
    assert property (flags.either_wrap_flag ==
      (flags.over_flag | flags.under_flag)) else $error("either flag");
  a_stage_hold:
    assert property (!(take | clr) |=> $stable(result))
    else $error("stage moved");
  a_stage_clear:
    assert property (clr |=> result == 0 && flags == '0)
    else $error("stage clear");
  c_over: cover property (flags.over_flag);
  c_under: cover property (flags.under_flag);
  c_clear: cover property (clr ##1 result == 0);
endmodule

bind dsa_alu dsa_alu_chk CHK (.clk(clk), .rst_b(rst_b),
  .clock_source_a(clock_source_a), .clock_source_b(clock_source_b),
  .clock_source_c(clock_source_c), .clock_source_d(clock_source_d),
  .ce_src(ce_src), .rst_src(rst_src), .out_cfg(out_cfg), .mask(mask),
  .pattern(pattern), .result(result), .cascade_out(cascade_out),
  .flags(flags));

//--- verif/dsa_nbr_slice.sv
/*
  Neighbouring slice seen from the cascade input: a registered sum.
  Assumes the bench loads it on the shared clock.
*/
`timescale 1ns/1ps
module dsa_nbr_slice
  import dsa_pkg::*;
(
  input wire logic clk, // clock
  input wire logic rst_b, // reset
  input wire logic load, // take new sum
  input wire logic [53:0] value, // sum to present
  output logic [53:0] psum // to cascade input
);
  // registered partial sum
  // Registered like a real output stage, never changing mid-cycle
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
      psum <= DSA_ZERO;
    else if (load)
      psum <= value;
endmodule

//--- verif/dsa_alu_tb.sv
/*
  Bench for the slice: cascade, multiply, wrap, flags, rounding,
  accumulate and stage selects. Assumes the checker and neighbour.
*/
`timescale 1ns/1ps
module dsa_alu_tb
  import dsa_pkg::*;
;
  logic clk, rst_b, src_a, src_b, src_c, src_d, bypass_mult, acc_en;
  logic acc_load, add_sub, round_dyn_up, nbr_load;
  logic [3:0] ce_src, rst_src;
  dsa_stage_cfg_type in_cfg, pipe_cfg, out_cfg;
  logic [17:0] mul_a;
  logic [35:0] mul_b;
  logic [53:0] addend, c_in, cascade_in, nbr_val, mask, pattern, result;
  logic [5:0] round_bits;
  dsa_third_type third_sel;
  dsa_round_type round_mode;
  dsa_flags_type flags;
  int mismatches, total_checks, cycles;

  dsa_nbr_slice NBR (.clk(clk), .rst_b(rst_b), .load(nbr_load),
    .value(nbr_val), .psum(cascade_in));
  dsa_alu DUT (.clk(clk), .rst_b(rst_b), .clock_source_a(src_a),
    .clock_source_b(src_b), .clock_source_c(src_c),
    .clock_source_d(src_d), .ce_src(ce_src), .rst_src(rst_src),
    .in_cfg(in_cfg), .pipe_cfg(pipe_cfg), .out_cfg(out_cfg),
    .mul_a(mul_a), .mul_b(mul_b), .addend(addend), .c_in(c_in),
    .cascade_in(cascade_in), .bypass_mult(bypass_mult),
    .third_sel(third_sel), .acc_en(acc_en), .acc_load(acc_load),
    .add_sub(add_sub), .round_mode(round_mode), .round_bits(round_bits),
    .round_dyn_up(round_dyn_up), .mask(mask), .pattern(pattern),
    .result(result), .cascade_out(), .flags(flags));

  // ********************
  // Helpers
  // ********************
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task results;
    if (mismatches == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Hang guard, well above the roughly 125 cycles needed
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      mismatches++;
      results;
    end
  end

  task check(input string what, input logic [53:0] exp, got);
    total_checks++;
    if (got !== exp)
    begin
      $display("BAD %s exp %h got %h", what, exp, got);
      mismatches++;
    end
  endtask

  // Sample at the falling edge so the capture edge has settled
  task run(input int n, input string what, input logic [53:0] exp);
    repeat (n) @(posedge clk);
    @(negedge clk);
    check(what, exp, result);
  endtask

  task chkf(input logic [7:0] exp);
    check("flags", {46'h0, exp}, {46'h0, flags});
  endtask

  // ********************
  // Scenarios
  // ********************
  task t_sums;
    @(posedge clk);
    nbr_val <= 54'h1000;
    nbr_load <= 1'b1;
    addend <= 54'h2a;
    third_sel <= THIRD_CASCADE;
    run(4, "cascade", 54'h102a);
    @(posedge clk);
    third_sel <= THIRD_C;
    c_in <= 54'h500;
    run(4, "c sum", 54'h52a);
    @(posedge clk);
    add_sub <= 1'b1;
    run(1, "sub", 54'h4d6);
    @(posedge clk);
    add_sub <= 1'b0;
    third_sel <= THIRD_ZERO;
    bypass_mult <= 1'b0;
    mul_a <= 18'h3fffe;
    mul_b <= 36'h7;
    run(4, "product", 54'h3ffffffffffff2);
  endtask

  task t_flags;
    @(posedge clk);
    bypass_mult <= 1'b1;
    third_sel <= THIRD_C;
    mask <= DSA_ALL_ONES;
    c_in <= 54'h1fffffffffffff;
    addend <= DSA_ONE;
    run(4, "over", 54'h20000000000000);
    chkf(8'h7d);
    @(posedge clk);
    c_in <= 54'h20000000000000;
    add_sub <= 1'b1;
    run(4, "under", 54'h1fffffffffffff);
    chkf(8'h7b);
    @(posedge clk);
    mask <= DSA_ZERO;
    pattern <= 54'h3fffffffffedcb;
    c_in <= 54'h1234;
    add_sub <= 1'b0;
    addend <= DSA_ZERO;
    run(4, "inverse", 54'h1234);
    chkf(8'h08);
    @(posedge clk);
    pattern <= DSA_ZERO;
    c_in <= DSA_ZERO;
    run(4, "zero", DSA_ZERO);
    chkf(8'hd0);
  endtask

  task automatic t_round;
    dsa_round_type md [7] = '{RND_NONE, RND_TOWARD_ZERO,
      RND_TOWARD_INFINITY, RND_DYNAMIC, RND_CONVERGENT, RND_CONVERGENT,
      RND_TOWARD_ZERO};
    logic [53:0] vi [7] = '{54'h18, 54'h18, 54'h18, 54'h18, 54'h18,
      54'h28, 54'h3fffffffffffe8};
    logic [53:0] vo [7] = '{54'h18, 54'h10, 54'h20, 54'h20, 54'h20,
      54'h20, 54'h3ffffffffffff0};
    for (int i = 0; i < 7; i++)
    begin
      @(posedge clk);
      round_bits <= 6'h4;
      round_mode <= md[i];
      c_in <= vi[i];
      run(4, "round", vo[i]);
    end
    // Dynamic choice down: -24 must settle on -32
    @(posedge clk);
    round_mode <= RND_DYNAMIC;
    round_dyn_up <= 1'b0;
    run(4, "dyn down", 54'h3fffffffffffe0);
    // Random constant may land on either neighbour of -24
    @(posedge clk);
    round_mode <= RND_RANDOM;
    repeat (4) @(posedge clk);
    @(negedge clk);
    check("random low", DSA_ZERO, result & 54'hf);
    check("random near", 54'h3fffffffffffe0, result & ~54'h10);
  endtask

  task t_acc;
    @(posedge clk);
    round_mode <= RND_NONE;
    third_sel <= THIRD_ZERO;
    c_in <= 54'h64;
    addend <= 54'h3;
    acc_load <= 1'b1;
    run(4, "acc init", 54'h67);
    @(posedge clk);
    acc_load <= 1'b0;
    acc_en <= 1'b1;
    run(5, "acc sum", 54'h76);
    @(posedge clk);
    add_sub <= 1'b1;
    run(2, "acc minus", 54'h73);
  endtask

  task t_stage;
    @(posedge clk);
    {acc_en, add_sub} <= 2'h0;
    third_sel <= THIRD_C;
    addend <= DSA_ZERO;
    c_in <= 54'h11;
    out_cfg.clk_sel <= 2'h2;
    run(4, "source c", 54'h11);
    @(posedge clk);
    src_c <= 1'b0;
    c_in <= 54'h22;
    run(4, "no tick", 54'h11);
    @(posedge clk);
    src_c <= 1'b1;
    out_cfg.ce_sel <= 2'h1;
    ce_src <= 4'hd;
    run(4, "no enable", 54'h11);
    @(posedge clk);
    ce_src <= 4'hf;
    run(4, "enable", 54'h22);
    @(posedge clk);
    out_cfg.rst_sel <= 2'h3;
    rst_src <= 4'h8;
    run(2, "clear", DSA_ZERO);
    chkf(8'h00);
  endtask

  // ********************
  // Main sequence
  // ********************
  initial
  begin
    rst_b = 1'b0;
    {src_a, src_b, src_c, src_d} = 4'hf;
    {bypass_mult, acc_en, acc_load, add_sub, nbr_load} = 5'h10;
    round_dyn_up = 1'b1;
    {ce_src, rst_src} = 8'hf0;
    {in_cfg, pipe_cfg, out_cfg} = '0;
    {mul_a, mul_b} = '0;
    {addend, c_in, nbr_val, mask, pattern} = '0;
    round_bits = 6'h0;
    third_sel = THIRD_ZERO;
    round_mode = RND_NONE;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    @(negedge clk);
    check("reset", DSA_ZERO, result);
    t_sums;
    t_flags;
    t_round;
    t_acc;
    t_stage;
    results;
  end
endmodule
